// File: sauart_defines.vh
// constants for the serial uart: fifo sizes, entry layout, timing counts
// assumes a 100 mhz sys_clk; included by sauart_top.v and sauart_fifo.v
`ifndef SAUART_DEFINES_VH
`define SAUART_DEFINES_VH
// ==========================================================
// sizes
`define SAUART_FIFO_DEPTH 36
`define SAUART_TX_WIDTH 8
`define SAUART_RX_WIDTH 11
// ==========================================================
// receive entry fields
`define SAUART_RX_BRK_BIT 10
`define SAUART_RX_FRM_BIT 9
`define SAUART_RX_PAR_BIT 8
// ==========================================================
// timing
`define SAUART_OVERSAMPLE 16
`define SAUART_CLK_MHZ 100
`define SAUART_MAX_BAUD_KBPS 12500
`define SAUART_MIN_DIV (`SAUART_CLK_MHZ * 1000 / (`SAUART_MAX_BAUD_KBPS * 2))
`define SAUART_DIV_RESET 16'h0036
`define SAUART_TIMEOUT_BITS 4
`define SAUART_IR_SHORT 3
`define SAUART_IR_LONG 4
`endif

// File: sauart_fifo.v
// simple synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
`include "sauart_defines.vh"
module sauart_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `SAUART_FIFO_DEPTH,
  parameter AW = 6
) (
  input wire sys_clk,
  input wire arst_n,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output reg [AW:0] count
);
  // ==========================================================
  // storage
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  always @(posedge sys_clk) begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule // sauart_fifo

// File: sauart_top.v
// serial uart: framing, fifos, flow control, infrared coding, baud sense
// assumes control bits are static while a character is in flight
//
// What this block does
// - send words framed by start and stop bits; receive and unframe them
// - optional parity bit added on send, checked on receive, mismatch flagged in fifo mode
// - five to eight data bits, parity on or off, one or two stops
// - legacy one-deep mode and fifo mode, chosen by the fifo_mode input
// - transmit fifo holds 36 eight-bit words
// - receive fifo holds 36 eleven-bit entries: break, framing, parity flags
// - timeout flag when the line went quiet with data still waiting
// - drive request-to-send to pace far end; wait for clear-to-send
// - infrared mode: zero sent as 3/16 or 4/16 bit pulse, decoded back
// - dma requests for transmit and receive paths
// - receiver can measure incoming baud rate and set its divider
// - modem inputs synchronised and shown to software
// - timing from device clock, up to 1.25 mbit/s from baud_div, 6.25 mbit/s once sensed
`timescale 1ns/1ns
`include "sauart_defines.vh"
module sauart_top #(
  parameter FIFO_DEPTH = `SAUART_FIFO_DEPTH,
  parameter MODEM_W = 4
) (
  input wire sys_clk,
  input wire arst_n,
  input wire fifo_mode,
  input wire [1:0] word_len,
  input wire parity_en,
  input wire parity_odd,
  input wire two_stop,
  input wire infrared_pulse_mode,
  input wire ir_long_pulse,
  input wire loopback,
  input wire flow_en,
  input wire autobaud_start,
  input wire [15:0] baud_div,
  input wire tx_valid,
  output wire tx_ready,
  input wire [7:0] tx_data,
  output wire rx_valid,
  input wire rx_ready,
  output wire [10:0] rx_data,
  output reg rx_timeout,
  output wire tx_dma_req,
  output wire rx_dma_req,
  output reg [15:0] active_div,
  output reg autobaud_busy,
  output reg [MODEM_W-1:0] modem_status,
  input wire [MODEM_W-1:0] modem_in,
  output reg uart_tx,
  input wire uart_rx,
  input wire cts_n,
  output reg rts_n
);
  // constants sized to the signals that use them
  localparam [3:0] IR_SHORT_W = `SAUART_IR_SHORT;
  localparam [3:0] IR_LONG_W = `SAUART_IR_LONG;
  localparam [15:0] MIN_DIV = `SAUART_MIN_DIV;
  localparam [5:0] TIMEOUT_TICKS = `SAUART_TIMEOUT_BITS * 10;
  // ==========================================================
  // pin synchronisers
  reg rx_s1, rx_s2, cts_s1, cts_s2;
  reg [MODEM_W-1:0] modem_s1;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
      modem_s1 <= {MODEM_W{1'b0}};
      modem_status <= {MODEM_W{1'b0}};
    end else begin
      rx_s1 <= uart_rx;
      rx_s2 <= rx_s1;
      cts_s1 <= cts_n;
      cts_s2 <= cts_s1;
      modem_s1 <= modem_in;
      modem_status <= modem_s1;
    end
  end
  // ==========================================================
  // fifos; legacy mode caps occupancy at one word
  wire [6:0] txf_count, rxf_count;
  wire txf_in_ready, txf_out_valid, rxf_in_ready;
  wire [7:0] txf_out;
  reg tx_pop, rx_push;
  reg [10:0] rx_entry;
  wire cap_tx = !fifo_mode && (txf_count != 7'h00);
  wire cap_rx = !fifo_mode && (rxf_count != 7'h00);
  assign tx_ready = txf_in_ready && !cap_tx;
  sauart_fifo #(.WIDTH(`SAUART_TX_WIDTH), .DEPTH(FIFO_DEPTH), .AW(6)) u_txf (
    .sys_clk(sys_clk), .arst_n(arst_n), .flush(1'b0),
    .in_valid(tx_valid && !cap_tx), .in_ready(txf_in_ready), .in_data(tx_data),
    .out_valid(txf_out_valid), .out_ready(tx_pop), .out_data(txf_out),
    .count(txf_count));
  sauart_fifo #(.WIDTH(`SAUART_RX_WIDTH), .DEPTH(FIFO_DEPTH), .AW(6)) u_rxf (
    .sys_clk(sys_clk), .arst_n(arst_n), .flush(1'b0),
    .in_valid(rx_push && !cap_rx), .in_ready(rxf_in_ready), .in_data(rx_entry),
    .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data),
    .count(rxf_count));
  assign tx_dma_req = tx_ready;
  assign rx_dma_req = rx_valid;
  // ==========================================================
  // flow control: hold off far end when the receive side is nearly full
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      rts_n <= 1'b1;
    else
      rts_n <= flow_en && (cap_rx || rxf_count >= (FIFO_DEPTH - 4));
  end
  // ==========================================================
  // transmitter, 16 ticks per bit
  wire [3:0] nbits = 4'h5 + {2'b00, word_len};
  reg [15:0] tx_div_cnt;
  reg [3:0] tx_tick;
  reg [3:0] tx_bitn;
  reg [11:0] tx_shift;
  reg tx_busy;
  wire tx_tick_en = (tx_div_cnt == 16'h0000);
  wire tx_parity = ^(txf_out & ~(8'hFF << nbits)) ^ parity_odd;
  reg [3:0] tx_len;
  wire tx_bit = tx_shift[0];
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_div_cnt <= 16'h0000;
      tx_tick <= 4'h0;
      tx_bitn <= 4'h0;
      tx_shift <= 12'hFFF;
      tx_busy <= 1'b0;
      tx_len <= 4'h0;
      tx_pop <= 1'b0;
    end else begin
      tx_pop <= 1'b0;
      tx_div_cnt <= tx_tick_en ? active_div : tx_div_cnt - 16'h0001;
      if (!tx_busy) begin
        if (txf_out_valid && !tx_pop && (!flow_en || !cts_s2)) begin
          // start, data lsb first, parity, stops
          tx_shift <= ({4'hF, txf_out} & ~(12'hFFF << nbits)) << 1
            | (parity_en ? {11'h000, tx_parity} << (nbits + 4'h1) : 12'h000)
            | (12'hFFF << (nbits + 4'h1 + {3'b000, parity_en}));
          tx_len <= nbits + 4'h2 + {3'b000, parity_en} + {3'b000, two_stop};
          tx_bitn <= 4'h0;
          tx_tick <= 4'h0;
          // restart the divider so the start bit is a whole bit long
          tx_div_cnt <= active_div;
          tx_busy <= 1'b1;
          tx_pop <= 1'b1;
        end
      end else if (tx_tick_en) begin
        tx_tick <= tx_tick + 4'h1;
        if (tx_tick == 4'hF) begin
          tx_shift <= {1'b1, tx_shift[11:1]};
          tx_bitn <= tx_bitn + 4'h1;
          if (tx_bitn == tx_len - 4'h1)
            tx_busy <= 1'b0;
        end
      end
    end
  end
  // infrared: zero becomes a short high pulse at the start of the bit
  wire [3:0] ir_w = ir_long_pulse ? IR_LONG_W : IR_SHORT_W;
  wire line_out = !tx_busy || tx_bit;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      uart_tx <= 1'b1;
    else if (infrared_pulse_mode)
      uart_tx <= !line_out && (tx_tick < ir_w);
    else
      uart_tx <= line_out;
  end
  // ==========================================================
  // receiver front end: loopback and infrared decode
  reg ir_stretch;
  reg [3:0] ir_cnt;
  reg [15:0] rx_div_cnt;
  wire rx_tick_en = (rx_div_cnt == 16'h0000);
  wire raw_in = loopback ? uart_tx : rx_s2;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_cnt <= 4'h0;
      ir_stretch <= 1'b0;
    end else if (raw_in) begin
      ir_cnt <= 4'hF;
      ir_stretch <= 1'b1;
    end else if (rx_tick_en && ir_cnt != 4'h0) begin
      ir_cnt <= ir_cnt - 4'h1;
    end else if (ir_cnt == 4'h0) begin
      ir_stretch <= 1'b0;
    end
  end
  // a pulse marks a zero bit, stretched across the bit period
  wire rx_line = infrared_pulse_mode ? !ir_stretch : raw_in;
  // ==========================================================
  // receiver, mid-bit sampling
  reg [3:0] rx_tick;
  reg rx_wait_high;
  reg [3:0] rx_bitn;
  reg [8:0] rx_shift;
  reg rx_busy, rx_allzero;
  reg [5:0] idle_ticks;
  wire [3:0] rx_dlen = nbits + {3'b000, parity_en};
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_div_cnt <= 16'h0000;
      rx_tick <= 4'h0;
      rx_bitn <= 4'h0;
      rx_shift <= 9'h000;
      rx_busy <= 1'b0;
      rx_allzero <= 1'b0;
      rx_wait_high <= 1'b0;
      rx_push <= 1'b0;
      rx_entry <= 11'h000;
      idle_ticks <= 6'h00;
      rx_timeout <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      rx_div_cnt <= rx_tick_en ? active_div : rx_div_cnt - 16'h0001;
      if (!rx_busy) begin
        // after a low stop the line must go high first, else a break repeats
        if (rx_wait_high) begin
          if (rx_line)
            rx_wait_high <= 1'b0;
        end else if (!rx_line && !autobaud_busy) begin
          rx_busy <= 1'b1;
          rx_tick <= 4'h0;
          rx_bitn <= 4'h0;
          rx_allzero <= 1'b1;
          rx_div_cnt <= active_div;
        end
      end else if (rx_tick_en) begin
        rx_tick <= rx_tick + 4'h1;
        if (rx_tick == 4'h7) begin
          if (rx_bitn == 4'h0 && rx_line) begin
            rx_busy <= 1'b0; // glitch, not a start bit
          end else if (rx_bitn != 4'h0 && rx_bitn <= rx_dlen) begin
            rx_shift[rx_bitn - 4'h1] <= rx_line;
            if (rx_line)
              rx_allzero <= 1'b0;
          end else if (rx_bitn > rx_dlen) begin
            rx_busy <= 1'b0;
            rx_wait_high <= !rx_line;
            rx_push <= 1'b1;
            rx_entry[7:0] <= rx_shift[7:0] & ~(8'hFF << nbits);
            rx_entry[`SAUART_RX_BRK_BIT] <= fifo_mode && rx_allzero && !rx_line;
            rx_entry[`SAUART_RX_FRM_BIT] <= fifo_mode && !rx_line;
            rx_entry[`SAUART_RX_PAR_BIT] <= fifo_mode && parity_en &&
              ((^(rx_shift & ~(9'h1FF << nbits))) ^ rx_shift[nbits] ^ parity_odd);
          end
        end
        if (rx_tick == 4'hF)
          rx_bitn <= rx_bitn + 4'h1;
      end
      // timeout: quiet line for several character times with data pending
      if (rx_busy || !rx_valid || !rx_line)
        idle_ticks <= 6'h00;
      else if (rx_tick_en && rx_tick == 4'hF && idle_ticks != 6'h3F)
        idle_ticks <= idle_ticks + 6'h01;
      if (rx_tick_en && !rx_busy)
        rx_tick <= rx_tick + 4'h1;
      rx_timeout <= rx_valid && (idle_ticks >= TIMEOUT_TICKS);
    end
  end
  // ==========================================================
  // baud sense: time the start bit of a 0x55-style sync character
  // assumes the first low pulse is exactly one bit long
  reg [19:0] ab_cnt;
  reg ab_low;
  // a sensed divider is kept until reset or until the next sensing ends; baud_div is ignored until reset
  reg ab_hold;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_div <= `SAUART_DIV_RESET;
      autobaud_busy <= 1'b0;
      ab_cnt <= 20'h00000;
      ab_low <= 1'b0;
      ab_hold <= 1'b0;
    end else if (!autobaud_busy) begin
      if (!ab_hold)
        active_div <= (baud_div < MIN_DIV) ? MIN_DIV : baud_div;
      if (autobaud_start) begin
        autobaud_busy <= 1'b1;
        ab_low <= 1'b0;
        ab_cnt <= 20'h00000;
      end
    end else if (!ab_low) begin
      if (!rx_line) begin
        ab_low <= 1'b1;
        ab_cnt <= 20'h00001;
      end
    end else if (!rx_line) begin
      if (ab_cnt != 20'hFFFFF)
        ab_cnt <= ab_cnt + 20'h00001;
    end else begin
      // divide bit length by 16 ticks per bit, minus the reload cycle
      active_div <= (ab_cnt[19:4] == 16'h0000) ? 16'h0000 : ab_cnt[19:4] - 16'h0001;
      autobaud_busy <= 1'b0;
      ab_hold <= 1'b1;
    end
  end
endmodule // sauart_top

// File: sauart_chk_sva.sv
// checker for sauart_top: timing relations between its ports
// assumes it is bound onto sauart_top and sees only its ports
`timescale 1ns/1ns
module sauart_chk #(
  parameter MODEM_W = 4
) (
  input wire sys_clk,
  input wire arst_n,
  input wire fifo_mode,
  input wire infrared_pulse_mode,
  input wire ir_long_pulse,
  input wire flow_en,
  input wire tx_valid,
  input wire tx_ready,
  input wire rx_valid,
  input wire [10:0] rx_data,
  input wire rx_timeout,
  input wire tx_dma_req,
  input wire rx_dma_req,
  input wire [15:0] active_div,
  input wire [MODEM_W-1:0] modem_status,
  input wire [MODEM_W-1:0] modem_in,
  input wire uart_tx,
  input wire cts_n,
  input wire rts_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ========
  // run lengths of the line; high run saturates so a long idle never wraps
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt <= 16'h0000;
      lo_cnt <= 16'h0000;
    end else begin
      hi_cnt <= uart_tx ? hi_cnt + {15'h0000, ~&hi_cnt} : 16'h0000;
      lo_cnt <= uart_tx ? 16'h0000 : lo_cnt + 16'h0001;
    end
  end
  // ========
  property p_dma;
    tx_dma_req == tx_ready && rx_dma_req == rx_valid;
  endproperty
  a_dma: assert property (p_dma) else $error("dma request mismatch");
  property p_legacy_hold;
    !fifo_mode && tx_valid && tx_ready |=> !tx_ready;
  endproperty
  a_legacy_hold: assert property (p_legacy_hold) else $error("legacy took 2 words");
  property p_legacy_flags;
    !fifo_mode && rx_valid |-> rx_data[10:8] == 3'h0;
  endproperty
  a_legacy_flags: assert property (p_legacy_flags) else $error("flags in legacy");
  property p_rts;
    (flow_en && !fifo_mode && rx_valid)[*4] |-> rts_n;
  endproperty
  a_rts: assert property (p_rts) else $error("rts low with word held");
  property p_cts;
    flow_en && cts_n && $past(cts_n, 3) && hi_cnt > 16'h03E8 |-> uart_tx;
  endproperty
  a_cts: assert property (p_cts) else $error("start while cts high");
  property p_modem;
    $stable(modem_in)[*4] |-> modem_status == modem_in;
  endproperty
  a_modem: assert property (p_modem) else $error("modem status stale");
  // a low run is a whole number of bit periods
  property p_bit_len;
    !infrared_pulse_mode && $rose(uart_tx) |-> lo_cnt % (16 * (active_div + 1)) == 0;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit length wrong");
  // bounds skip the idle-level change on entry to infrared mode
  property p_ir_pulse;
    infrared_pulse_mode && $fell(uart_tx) && hi_cnt > 16'h0002 && hi_cnt < 16'h00C8
      |-> hi_cnt == (ir_long_pulse ? 16'h0004 : 16'h0003) * (active_div + 16'h0001);
  endproperty
  a_ir_pulse: assert property (p_ir_pulse) else $error("ir pulse width wrong");
  property p_timeout;
    $rose(rx_timeout) |-> rx_valid;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout with no data");
endmodule // sauart_chk
bind sauart_top sauart_chk #(.MODEM_W(MODEM_W)) u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .fifo_mode(fifo_mode), .infrared_pulse_mode(infrared_pulse_mode),
  .ir_long_pulse(ir_long_pulse), .flow_en(flow_en), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_timeout(rx_timeout),
  .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .active_div(active_div),
  .modem_status(modem_status), .modem_in(modem_in), .uart_tx(uart_tx), .cts_n(cts_n),
  .rts_n(rts_n));

// File: sauart_far.sv
// far serial device: sends frames and decodes frames from the uart
// assumes bits of BIT clocks, changes made at the falling edge
`timescale 1ns/1ns
module sauart_far #(
  parameter int BIT = 80
) (
  input wire logic sys_clk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // ========
  // frame goes lsb first, start bit at index 0; line back high after
  task automatic send(input logic [11:0] fr, input int n);
    for (int i = 0; i < n; i++) begin
      line_out = fr[i];
      repeat (BIT) @(negedge sys_clk);
    end
    line_out = 1'b1;
  endtask
  // no start seen within the bound leaves fr high, so the compare fails
  task automatic recv(input int n, output logic [11:0] fr);
    int w;
    fr = 12'h000;
    w = 0;
    while (line_in === 1'b1 && w < 6000) begin
      @(negedge sys_clk);
      w++;
    end
    repeat (BIT / 2) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      fr[i] = line_in;
      if (i < n - 1) repeat (BIT) @(negedge sys_clk);
    end
  endtask
endmodule // sauart_far

// File: test_serial_async_uart.sv
// bench for sauart_top: random formats, line errors, modes
// assumes sauart_far on the serial lines and the checker bound in
`timescale 1ns/1ns
`include "sauart_defines.vh"
module test_serial_async_uart;
  localparam int BIT = 80;
  localparam int LIM = 6000;
  logic sys_clk, arst_n, fifo_mode, parity_en, parity_odd, two_stop, infrared_pulse_mode;
  logic ir_long_pulse, loopback, flow_en, autobaud_start, tx_valid, rx_ready, cts_n;
  logic [1:0] word_len;
  logic [15:0] baud_div;
  logic [7:0] tx_data, d;
  logic [3:0] modem_in;
  logic [11:0] fr;
  wire tx_ready, rx_valid, rx_timeout, autobaud_busy, uart_tx, rts_n, line;
  wire [10:0] rx_data;
  wire [15:0] active_div;
  wire [3:0] modem_status;
  int error_cnt, n_checks, w, nb, n, bad;
  sauart_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .fifo_mode(fifo_mode),
    .word_len(word_len), .parity_en(parity_en), .parity_odd(parity_odd), .two_stop(two_stop),
    .infrared_pulse_mode(infrared_pulse_mode), .ir_long_pulse(ir_long_pulse),
    .loopback(loopback), .flow_en(flow_en), .autobaud_start(autobaud_start),
    .baud_div(baud_div), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_timeout(rx_timeout),
    .tx_dma_req(), .rx_dma_req(), .active_div(active_div), .autobaud_busy(autobaud_busy),
    .modem_status(modem_status), .modem_in(modem_in), .uart_tx(uart_tx), .uart_rx(line),
    .cts_n(cts_n), .rts_n(rts_n));
  sauart_far #(.BIT(BIT)) far (.sys_clk(sys_clk), .line_in(uart_tx), .line_out(line));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ========
  // expected frame, bits above the frame length cleared
  function automatic logic [11:0] frame(input logic [7:0] v, input int k, pe, po, ts);
    logic [11:0] f;
    f = 12'hFFE;
    for (int i = 0; i < k; i++) f[i + 1] = v[i];
    if (pe) f[k + 1] = ^(v & (8'hFF >> (8 - k))) ^ po[0];
    return f & ~(12'hFFF << (2 + k + pe + ts));
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic guard;
    if (w >= LIM) begin
      error_cnt++;
      close_out;
    end
  endtask
  task automatic do_reset;
    arst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk({uart_tx, rts_n, rx_valid, tx_ready, autobaud_busy}, 16'h001A);
    chk(active_div, 16'h0036);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic push(input logic [7:0] v);
    tx_data = v;
    tx_valid = 1'b1;
    w = 0;
    while (tx_ready !== 1'b1 && w < LIM) begin
      @(negedge sys_clk);
      w++;
    end
    guard;
    @(negedge sys_clk);
    tx_valid = 1'b0;
  endtask
  task automatic wait_rx;
    w = 0;
    while (rx_valid !== 1'b1 && w < LIM) begin
      @(negedge sys_clk);
      w++;
    end
    guard;
  endtask
  task automatic pop;
    rx_ready = 1'b1;
    @(negedge sys_clk);
    rx_ready = 1'b0;
  endtask
  // ========
  initial begin
    {arst_n, fifo_mode, parity_en, parity_odd, two_stop, infrared_pulse_mode} = '0;
    {ir_long_pulse, loopback, flow_en, autobaud_start, tx_valid, rx_ready, cts_n} = '0;
    {word_len, tx_data, modem_in} = '0;
    baud_div = 16'h0004;
    error_cnt = 0;
    n_checks = 0;
    w = $urandom(88);
    do_reset;
    chk(active_div, baud_div);
    fifo_mode = 1'b1;
    for (int c = 0; c < 16; c++) begin
      {parity_odd, parity_en, word_len} = c[3:0];
      two_stop = 1'($urandom);
      nb = 5 + c[1:0];
      d = 8'($urandom);
      n = 2 + nb + parity_en + two_stop;
      push(d);
      far.recv(n, fr);
      chk(fr, frame(d, nb, parity_en, parity_odd, two_stop));
      repeat (BIT) @(negedge sys_clk);
      bad = parity_en & 1'($urandom);
      fr = frame(d, nb, parity_en, parity_odd, 1);
      fr[nb + 1] = fr[nb + 1] ^ bad[0];
      far.send(fr, 3 + nb + parity_en);
      wait_rx;
      chk(rx_data, {bad[0], d & (8'hFF >> (8 - nb))});
      pop;
    end
    $display("format test done");
    {parity_en, word_len} = 3'h3;
    for (int c = 0; c < 2; c++) begin
      d = c ? 8'h00 : 8'h5A;
      far.send(frame(d, 8, 0, 0, 1) & 12'h1FF, 11);
      wait_rx;
      chk(rx_data, {c[0], 2'h2, d});
      w = 0;
      while (rx_timeout !== 1'b1 && w < LIM) begin
        @(negedge sys_clk);
        w++;
      end
      chk(rx_timeout, 1'b1);
      guard;
      pop;
    end
    $display("error flag test done");
    {fifo_mode, flow_en, parity_en} = 3'h3;
    push(8'hC3);
    far.send(frame(8'h3C, 8, 1, 0, 1) ^ 12'h200, 12);
    far.send(frame(8'h11, 8, 1, 0, 1), 12);
    chk(rx_data, 16'h003C);
    pop;
    chk(rx_valid, 1'b0);
    $display("legacy test done");
    fifo_mode = 1'b1;
    cts_n = 1'b1;
    repeat (2000) @(negedge sys_clk);
    n = 0;
    tx_valid = 1'b1;
    for (int c = 0; c < 40; c++) begin
      tx_data = 8'($urandom);
      n += tx_ready;
      @(negedge sys_clk);
    end
    tx_valid = 1'b0;
    chk(n[15:0], 16'(`SAUART_FIFO_DEPTH));
    chk(uart_tx, 1'b1);
    cts_n = 1'b0;
    do_reset;
    for (int c = 0; c < 4; c++) begin
      modem_in = 4'($urandom);
      repeat (5) @(negedge sys_clk);
      chk(modem_status, modem_in);
    end
    baud_div = 16'h0009;
    repeat (4) @(negedge sys_clk);
    autobaud_start = 1'b1;
    @(negedge sys_clk);
    autobaud_start = 1'b0;
    far.send(frame(8'h01, 8, 0, 0, 1), 11);
    w = 0;
    while (autobaud_busy !== 1'b0 && w < LIM) begin
      @(negedge sys_clk);
      w++;
    end
    guard;
    chk(active_div, 16'h0004);
    $display("fill, modem and baud test done");
    baud_div = 16'h0004;
    {infrared_pulse_mode, loopback, parity_en, word_len} = 5'h1B;
    do_reset;
    for (int c = 0; c < 2; c++) begin
      ir_long_pulse = c[0];
      d = 8'($urandom);
      push(d);
      wait_rx;
      chk(rx_data, {3'h0, d});
      pop;
      repeat (BIT) @(negedge sys_clk);
    end
    $display("infrared loopback test done");
    close_out;
  end
endmodule // test_serial_async_uart
